//--- hw/afc_classifier.sv
/*
 afc_classifier: ordered match-entry list with per-entry hit counters and actions,
 configured over AXI4-Lite, fed one frame descriptor at a time by the ingress pipeline.
 assumes: one clock, frame and result handshakes synchronous to clk_sys; the pipeline
 supplies frame length with VLAN tags already removed.
*/
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
module afc_classifier (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic frame_valid,
    output logic frame_ready,
    input wire afc_pkg::afc_frame_s frame_in,
    output logic result_valid,
    output afc_pkg::afc_result_s result
);
    import afc_pkg::*;

    afc_entry_s mem [ENTRIES];
    logic [31:0] cnt_mem [ENTRIES];
    logic [ENTRIES-1:0] valid_q;
    afc_state_e st_q;
    logic [8:0] scan_q;
    afc_frame_s frm_q;
    logic clr_pend_q;
    logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [8:0] idx_q;
    logic [31:0] key_q, act_q, source_station_address_lo_q, source_station_address_hi_q, dest_station_address_lo_q, dest_station_address_hi_q;
    logic frame_ready_q, res_valid_q;
    afc_result_s res_q;
    logic [8:0] last_idx_q;
    logic last_hit_q;

    afc_entry_s cur;
    logic cur_valid, hit_now, wr_fire, take_frame, cmd_ok;
    logic [31:0] cnt_cur;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic entry_match(input afc_entry_s e, input afc_frame_s f);
        logic m_port, m_pol, m_type, m_source_station_address, m_dest_station_address, bcast;
        m_port = e.key.port_any || (e.key.port == f.port);
        m_pol = !e.key.pol_spec || (((f.policy ^ e.key.pol_val) & e.key.pol_mask) == 8'h00);
        bcast = (f.dest_station_address == '1);
        unique case (e.key.ftype)
            FT_ANY: m_type = 1'b1;
            FT_ETHER_TYPE_CLASS: m_type = (f.fclass == FC_OTHER) && (f.len_type >= ETHER_TYPE_CLASS_MIN);
            FT_ARP: m_type = (f.fclass == FC_ARP);
            FT_IPV4: m_type = (f.fclass == FC_IPV4);
            FT_IPV6: m_type = (f.fclass == FC_IPV6);
            default: m_type = 1'b0;
        endcase
        m_source_station_address = !(e.key.source_station_address_spec && (e.key.ftype == FT_ETHER_TYPE_CLASS || e.key.ftype == FT_ARP)) || (f.source_station_address == e.source_station_address);
        unique case (e.key.dest_station_address_mode)
            DM_ANY: m_dest_station_address = 1'b1;
            DM_GROUP: m_dest_station_address = f.dest_station_address[IG_BIT] && !bcast;
            DM_ALL: m_dest_station_address = bcast;
            DM_SINGLE: m_dest_station_address = !f.dest_station_address[IG_BIT];
            DM_SPEC: m_dest_station_address = (f.dest_station_address == e.dest_station_address);
            default: m_dest_station_address = 1'b0;
        endcase
        return m_port && m_pol && m_type && m_source_station_address && m_dest_station_address;
    endfunction

    // reserved slots are constants, so software cannot rewrite or delete them; their hit counters still read and clear like any other
    assign cur = (scan_q < IDX_RSVD) ? RSVD_ENTRY : mem[scan_q];
    assign cur_valid = (scan_q < IDX_RSVD) || valid_q[scan_q];
    assign hit_now = (st_q == S_SCAN) && cur_valid && entry_match(cur, frm_q);
    assign cnt_cur = cnt_mem[scan_q];
    assign take_frame = frame_valid && frame_ready_q;
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    assign cmd_ok = (idx_q >= IDX_RSVD);

    // scan engine: one entry per cycle, stops at the first hit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= S_CLEAR;
            scan_q <= '0;
            frame_ready_q <= 1'b0;
        end else begin
            unique case (st_q)
                S_CLEAR: begin
                    scan_q <= scan_q + 9'h1;
                    if (scan_q == IDX_LAST) begin
                        st_q <= S_IDLE;
                        frame_ready_q <= !clr_pend_q;
                    end
                end
                S_IDLE: begin
                    scan_q <= '0;
                    // a frame already handed over must be scanned; the clear waits for the next idle
                    if (take_frame) begin
                        st_q <= S_SCAN;
                        frame_ready_q <= 1'b0;
                    end else if (clr_pend_q) begin
                        st_q <= S_CLEAR;
                        frame_ready_q <= 1'b0;
                    end else begin
                        frame_ready_q <= 1'b1;
                    end
                end
                S_SCAN: begin
                    scan_q <= scan_q + 9'h1;
                    if (hit_now || scan_q == IDX_LAST) begin
                        st_q <= S_IDLE;
                        scan_q <= '0;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                    scan_q <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            frm_q <= '0;
        end else if (take_frame) begin
            frm_q <= frame_in;
        end
    end

    // counters have no reset; the clear walk after reset zeroes them
    always_ff @(posedge clk_sys) begin
        if (st_q == S_CLEAR) begin
            cnt_mem[scan_q] <= '0;
        end else if (hit_now) begin
            cnt_mem[scan_q] <= cnt_cur + CNT_ONE;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            res_valid_q <= 1'b0;
            res_q <= '0;
            last_idx_q <= '0;
            last_hit_q <= 1'b0;
        end else begin
            res_valid_q <= 1'b0;
            if (st_q == S_SCAN && (hit_now || scan_q == IDX_LAST)) begin
                res_valid_q <= 1'b1;
                res_q <= '0;
                last_hit_q <= hit_now;
                if (hit_now) begin
                    last_idx_q <= scan_q;
                    res_q.hit <= 1'b1;
                    res_q.index <= scan_q;
                    res_q.drop <= cur.act.deny;
                    res_q.redir_en <= !cur.act.deny && cur.act.redir_en;
                    res_q.redir_port <= cur.act.redir_port;
                    // the limiter polices the forwarded copy only, never the mirror copy
                    res_q.mirror <= !cur.act.deny && cur.act.mirror;
                    if (cur.act.limiter != RL_NONE && cur.act.limiter <= RL_MAX) begin
                        res_q.limiter <= cur.act.limiter;
                    end
                    res_q.log <= cur.act.log && (frm_q.length < LEN_LIMIT);
                    res_q.shut <= cur.act.shut && (frm_q.length < LEN_LIMIT);
                    res_q.shut_port <= frm_q.port;
                end
            end
        end
    end

    // write channel: address and data accepted in either order
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            awready_q <= !aw_hold_q && !(s_axi_awvalid && awready_q);
            wready_q <= !w_hold_q && !(s_axi_wvalid && wready_q);
            if (s_axi_awvalid && awready_q) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                unique case (awaddr_q)
                    REG_CTRL, REG_STAT, REG_IDX, REG_KEY, REG_SOURCE_STATION_ADDRESS_LO, REG_SOURCE_STATION_ADDRESS_HI,
                    REG_DEST_STATION_ADDRESS_LO, REG_DEST_STATION_ADDRESS_HI, REG_ACT, REG_HITS: bresp_q <= RESP_OKAY;
                    REG_CMD: bresp_q <= cmd_ok ? RESP_OKAY : RESP_SLVERR;
                    default: bresp_q <= RESP_SLVERR;
                endcase
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // staging words for one entry, committed by the command register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            idx_q <= '0;
            key_q <= '0;
            act_q <= '0;
            source_station_address_lo_q <= '0;
            source_station_address_hi_q <= '0;
            dest_station_address_lo_q <= '0;
            dest_station_address_hi_q <= '0;
        end else if (wr_fire) begin
            unique case (awaddr_q)
                REG_IDX: idx_q <= 9'(merge(32'(idx_q), wdata_q, wstrb_q));
                REG_KEY: key_q <= merge(key_q, wdata_q, wstrb_q);
                REG_ACT: act_q <= merge(act_q, wdata_q, wstrb_q);
                REG_SOURCE_STATION_ADDRESS_LO: source_station_address_lo_q <= merge(source_station_address_lo_q, wdata_q, wstrb_q);
                REG_SOURCE_STATION_ADDRESS_HI: source_station_address_hi_q <= 32'(merge(source_station_address_hi_q, wdata_q, wstrb_q) & 32'h0000ffff);
                REG_DEST_STATION_ADDRESS_LO: dest_station_address_lo_q <= merge(dest_station_address_lo_q, wdata_q, wstrb_q);
                REG_DEST_STATION_ADDRESS_HI: dest_station_address_hi_q <= 32'(merge(dest_station_address_hi_q, wdata_q, wstrb_q) & 32'h0000ffff);
                default: idx_q <= idx_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wr_fire && awaddr_q == REG_CMD && cmd_ok && wdata_q[1:0] == CMD_WRITE) begin
            mem[idx_q] <= '{key: key_q, act: act_q, source_station_address: {source_station_address_hi_q[15:0], source_station_address_lo_q},
                dest_station_address: {dest_station_address_hi_q[15:0], dest_station_address_lo_q}};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            valid_q <= '0;
        end else if (wr_fire && awaddr_q == REG_CTRL && wdata_q[CTRL_RMV]) begin
            valid_q <= '0;
        end else if (wr_fire && awaddr_q == REG_CMD && cmd_ok) begin
            if (wdata_q[1:0] == CMD_WRITE) begin
                valid_q[idx_q] <= 1'b1;
            end else if (wdata_q[1:0] == CMD_DELETE) begin
                valid_q[idx_q] <= 1'b0;
            end
        end
    end

    // a request landing as the walk starts is kept: set wins over the clear
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clr_pend_q <= 1'b0;
        end else if (wr_fire && awaddr_q == REG_CTRL && wdata_q[CTRL_CLR]) begin
            clr_pend_q <= 1'b1;
        end else if (st_q == S_IDLE && !take_frame) begin
            clr_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            unique case (s_axi_araddr)
                REG_CTRL, REG_CMD: rdata_q <= '0;
                REG_STAT: rdata_q <= {20'h0, last_idx_q, last_hit_q, clr_pend_q, st_q != S_IDLE};
                REG_IDX: rdata_q <= {23'h0, idx_q};
                REG_KEY: rdata_q <= key_q;
                REG_ACT: rdata_q <= act_q;
                REG_SOURCE_STATION_ADDRESS_LO: rdata_q <= source_station_address_lo_q;
                REG_SOURCE_STATION_ADDRESS_HI: rdata_q <= source_station_address_hi_q;
                REG_DEST_STATION_ADDRESS_LO: rdata_q <= dest_station_address_lo_q;
                REG_DEST_STATION_ADDRESS_HI: rdata_q <= dest_station_address_hi_q;
                REG_HITS: rdata_q <= cnt_mem[idx_q];
                default: begin
                    rdata_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign frame_ready = frame_ready_q;
    assign result_valid = res_valid_q;
    assign result = res_q;

    a_clear_zeroes_count: assert property (@(posedge clk_sys) disable iff (rst)
        (st_q == S_CLEAR) |=> (cnt_mem[$past(scan_q)] == 32'h0))
        else $error("counter not zeroed by clear walk");
    a_remove_all_empty: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_fire && awaddr_q == REG_CTRL && wdata_q[CTRL_RMV]) |=> (valid_q == '0))
        else $error("entries still valid after remove-all");
    a_deny_drops_frame: assert property (@(posedge clk_sys) disable iff (rst)
        (hit_now && cur.act.deny) |=> (res_valid_q && res_q.drop && !res_q.mirror && !res_q.redir_en))
        else $error("denied frame not dropped");
    a_ether_type_class_floor_kept: assert property (@(posedge clk_sys) disable iff (rst)
        (hit_now && cur.key.ftype == FT_ETHER_TYPE_CLASS) |-> (frm_q.fclass == FC_OTHER && frm_q.len_type >= ETHER_TYPE_CLASS_MIN))
        else $error("ethernet-type entry hit by wrong frame");
    a_log_length_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (res_valid_q && res_q.log) |-> (frm_q.length < LEN_LIMIT))
        else $error("log reported for long frame");
    a_shut_port_length: assert property (@(posedge clk_sys) disable iff (rst)
        (res_valid_q && res_q.shut) |-> (frm_q.length < LEN_LIMIT && res_q.shut_port == frm_q.port))
        else $error("shutdown wrong port or long frame");
    a_hit_counts_once: assert property (@(posedge clk_sys) disable iff (rst)
        hit_now |=> (cnt_mem[$past(scan_q)] == $past(cnt_cur) + CNT_ONE))
        else $error("hit counter did not step by one");
    a_reserved_refused: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_fire && awaddr_q == REG_CMD && idx_q < IDX_RSVD) |=> (bvalid_q && bresp_q == RESP_SLVERR))
        else $error("reserved entry command not refused");
    a_first_hit_stops: assert property (@(posedge clk_sys) disable iff (rst)
        hit_now |=> (st_q == S_IDLE && res_valid_q && res_q.index == $past(scan_q)))
        else $error("scan went past first hit");
    a_scan_bounded: assert property (@(posedge clk_sys) disable iff (rst)
        take_frame |-> ##[1:513] res_valid_q)
        else $error("no result within list length");
endmodule

//--- hw/afc_pkg.sv
/*
 afc_pkg: constants, register map and carrier types of the frame classifier.
 assumes: shared by the classifier module, the feeder and the bench; no timescale needed.
*/
package afc_pkg;
    localparam int ENTRIES = 512;
    localparam int RSVD = 1;
    localparam logic [8:0] IDX_LAST = 9'(ENTRIES - 1);
    localparam logic [8:0] IDX_RSVD = 9'(RSVD);
    localparam logic [15:0] ETHER_TYPE_CLASS_MIN = 16'h0600;
    localparam logic [13:0] LEN_LIMIT = 14'h05ee;
    localparam logic [4:0] RL_NONE = 5'h00;
    localparam logic [4:0] RL_MAX = 5'h10;
    localparam int IG_BIT = 40;
    localparam logic [31:0] CNT_ONE = 32'h1;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_IDX = 8'h08;
    localparam logic [7:0] REG_CMD = 8'h0c;
    localparam logic [7:0] REG_KEY = 8'h10;
    localparam logic [7:0] REG_SOURCE_STATION_ADDRESS_LO = 8'h14;
    localparam logic [7:0] REG_SOURCE_STATION_ADDRESS_HI = 8'h18;
    localparam logic [7:0] REG_DEST_STATION_ADDRESS_LO = 8'h1c;
    localparam logic [7:0] REG_DEST_STATION_ADDRESS_HI = 8'h20;
    localparam logic [7:0] REG_ACT = 8'h24;
    localparam logic [7:0] REG_HITS = 8'h28;
    localparam int CTRL_CLR = 0;
    localparam int CTRL_RMV = 1;
    localparam logic [1:0] CMD_WRITE = 2'h1;
    localparam logic [1:0] CMD_DELETE = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {FT_ANY = 3'h0, FT_ETHER_TYPE_CLASS = 3'h1, FT_ARP = 3'h2,
        FT_IPV4 = 3'h3, FT_IPV6 = 3'h4} afc_ftype_e;
    typedef enum logic [1:0] {FC_OTHER = 2'h0, FC_ARP = 2'h1, FC_IPV4 = 2'h2, FC_IPV6 = 2'h3} afc_fclass_e;
    typedef enum logic [2:0] {DM_ANY = 3'h0, DM_GROUP = 3'h1, DM_ALL = 3'h2,
        DM_SINGLE = 3'h3, DM_SPEC = 3'h4} afc_dmode_e;
    typedef enum logic [1:0] {S_CLEAR = 2'b00, S_IDLE = 2'b01, S_SCAN = 2'b10} afc_state_e;

    typedef struct packed {
        logic [1:0] pad; afc_dmode_e dest_station_address_mode; logic source_station_address_spec; afc_ftype_e ftype;
        logic [7:0] pol_mask; logic [7:0] pol_val; logic pol_spec; logic [4:0] port; logic port_any;
    } afc_key_s;
    typedef struct packed {
        logic [16:0] pad; logic shut; logic log; logic mirror; logic [4:0] redir_port;
        logic redir_en; logic [4:0] limiter; logic deny;
    } afc_act_s;
    typedef struct packed {
        afc_key_s key; afc_act_s act; logic [47:0] source_station_address; logic [47:0] dest_station_address;
    } afc_entry_s;
    typedef struct packed {
        logic [4:0] port; logic [7:0] policy; afc_fclass_e fclass; logic [15:0] len_type;
        logic [47:0] source_station_address; logic [47:0] dest_station_address; logic [13:0] length;
    } afc_frame_s;
    typedef struct packed {
        logic hit; logic [8:0] index; logic drop; logic redir_en; logic [4:0] redir_port;
        logic mirror; logic [4:0] limiter; logic log; logic shut; logic [4:0] shut_port;
    } afc_result_s;

    // internal-protocol entry: permit slow-protocol frames ahead of everything else
    localparam afc_entry_s RSVD_ENTRY = '{key: '{pad: 2'h0, dest_station_address_mode: DM_SPEC, source_station_address_spec: 1'b0,
        ftype: FT_ANY, pol_mask: 8'h00, pol_val: 8'h00, pol_spec: 1'b0, port: 5'h00, port_any: 1'b1},
        act: '0, source_station_address: 48'h0, dest_station_address: 48'h0180c2000002};
endpackage

//--- testbench/afc_feeder.sv
/*
 afc_feeder: behavioural ingress pipeline that offers one frame descriptor at a time.
 assumes: frame_ready is sampled at rising clk_sys edges; the bench calls send.
*/
`timescale 1ns/1ns
module afc_feeder (
    input wire logic clk_sys,
    input wire logic frame_ready,
    output logic frame_valid,
    output afc_pkg::afc_frame_s frame_in
);
    import afc_pkg::*;
    initial begin
        frame_valid = 1'b0;
        frame_in = '0;
    end
    // idle descriptor is inverted so a stale copy cannot pass for a fresh one
    task automatic send(input afc_frame_s f, input int unsigned gap);
        repeat (gap) @(posedge clk_sys);
        @(posedge clk_sys);
        frame_valid <= 1'b1;
        frame_in <= f;
        do @(posedge clk_sys); while (frame_ready !== 1'b1);
        frame_valid <= 1'b0;
        frame_in <= ~f;
    endtask
endmodule

//--- testbench/afc_classifier_bench.sv
/*
 afc_classifier_bench: programs entries over AXI4-Lite, sends frames, checks results and counters.
 assumes: afc_pkg and afc_feeder compiled first; 20 MHz clock.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("wrong value at %0t: %h expected %h", $time, (a), (b)); end end
module afc_classifier_bench;
    import afc_pkg::*;
    localparam logic [47:0] UNI = 48'h020000000001;
    logic clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, frame_valid, frame_ready, result_valid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    afc_frame_s frame_in;
    afc_result_s result;
    int bad_count = 0;
    int total_checks = 0;
    logic [59:0] q[$];
    logic [59:0] e;
    logic [59:0] miss;
    afc_classifier afc_classifier_i (.clk_sys(clk_sys), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .frame_valid(frame_valid), .frame_ready(frame_ready),
        .frame_in(frame_in), .result_valid(result_valid), .result(result));
    afc_feeder afc_feeder_i (.clk_sys(clk_sys), .frame_ready(frame_ready), .frame_valid(frame_valid),
        .frame_in(frame_in));
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // upper half is the expected result, lower half masks fields that carry no meaning
    function automatic logic [59:0] ex(logic h, logic [8:0] i, logic dr, logic ren, logic [4:0] rp, logic mi,
        logic [4:0] li, logic lg, logic sh, logic [4:0] sp);
        afc_result_s r;
        afc_result_s m;
        r = '{h, i, dr, ren, rp, mi, li, lg, sh, sp};
        m = '0;
        m.hit = 1'b1;
        if (h) begin
            m = '1;
            m.redir_port = ren ? 5'h1f : 5'h00;
            m.shut_port = sh ? 5'h1f : 5'h00;
        end
        return {r, m};
    endfunction
    function automatic afc_frame_s fr(logic [4:0] pt, logic [7:0] po, afc_fclass_e c, logic [15:0] lt,
        logic [47:0] sm, logic [47:0] dm, logic [13:0] ln);
        return '{pt, po, c, lt, sm, dm, ln};
    endfunction
    task automatic summarize;
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        `CHK(s_axi_bresp, r)
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk_sys);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        `CHK({s_axi_rresp, s_axi_rdata}, {r, d})
        s_axi_rready <= 1'b0;
    endtask
    task automatic prog(input logic [8:0] i, input afc_key_s k, input logic [47:0] sm, input afc_act_s ac);
        wr(REG_IDX, 32'(i), RESP_OKAY);
        wr(REG_KEY, k, RESP_OKAY);
        wr(REG_SOURCE_STATION_ADDRESS_LO, sm[31:0], RESP_OKAY);
        wr(REG_SOURCE_STATION_ADDRESS_HI, 32'(sm[47:32]), RESP_OKAY);
        wr(REG_ACT, ac, RESP_OKAY);
        wr(REG_CMD, 32'(CMD_WRITE), RESP_OKAY);
    endtask
    task automatic go(input afc_frame_s f, input logic [59:0] x);
        q.push_back(x);
        afc_feeder_i.send(f, $urandom_range(3, 0));
    endtask
    task automatic drain;
        while (q.size() != 0) @(posedge clk_sys);
        repeat (2) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        if (result_valid === 1'b1) begin
            `CHK(q.size() != 0, 1'b1)
            e = q.pop_front();
            `CHK(result & e[29:0], e[59:30] & e[29:0])
        end
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        bad_count++;
        summarize();
    end
    initial begin
        logic [47:0] s;
        logic [3:0] p;
        void'($urandom(32'he9c7));
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        miss = ex(0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
        s = {16'($urandom), $urandom};
        p = 4'($urandom);
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        prog(9'd5, afc_key_s'{2'h0, DM_ANY, 1'b1, FT_ETHER_TYPE_CLASS, 8'h00, 8'h00, 1'b0, 5'd3, 1'b0}, s,
            afc_act_s'{17'h0, 1'b1, 1'b1, 1'b0, 5'd0, 1'b0, RL_NONE, 1'b1});
        prog(9'd3, afc_key_s'{2'h0, DM_GROUP, 1'b0, FT_ANY, 8'h0f, 8'ha5, 1'b1, 5'd0, 1'b1}, 48'h0,
            afc_act_s'{17'h0, 1'b0, 1'b0, 1'b1, 5'd7, 1'b1, RL_MAX, 1'b0});
        go(fr(5'd9, 8'h00, FC_OTHER, 16'h8899, s, 48'h0180c2000002, 14'd64), ex(1, 0, 0, 0, 0, 0, 0, 0, 0, 0));
        go(fr(5'd3, {p, 4'h5}, FC_IPV4, 16'h0800, s, 48'h01005e000001, 14'd64),
            ex(1, 3, 0, 1, 7, 1, RL_MAX, 0, 0, 0));
        go(fr(5'd3, {p, 4'h4}, FC_IPV4, 16'h0800, s, 48'h01005e000001, 14'd64), miss);
        go(fr(5'd3, {p, 4'h5}, FC_IPV4, 16'h0800, s, 48'hffffffffffff, 14'd64), miss);
        go(fr(5'd3, 8'h00, FC_OTHER, 16'h0600, s, UNI, 14'd1517), ex(1, 5, 1, 0, 0, 0, 0, 1, 1, 3));
        go(fr(5'd3, 8'h00, FC_OTHER, 16'h0600, s, UNI, 14'd1518), ex(1, 5, 1, 0, 0, 0, 0, 0, 0, 0));
        go(fr(5'd4, 8'h00, FC_OTHER, 16'h0600, s, UNI, 14'd1517), miss);
        go(fr(5'd3, 8'h00, FC_OTHER, 16'h05ff, s, UNI, 14'd1517), miss);
        go(fr(5'd3, 8'h00, FC_ARP, 16'h0806, s, UNI, 14'd1517), miss);
        go(fr(5'd3, 8'h00, FC_OTHER, 16'h0600, s ^ 48'h1, UNI, 14'd1517), miss);
        drain();
        wr(REG_IDX, 32'h5, RESP_OKAY);
        rd(REG_HITS, 32'h2, RESP_OKAY);
        wr(REG_CTRL, 32'h1, RESP_OKAY);
        // the counter walk takes one cycle per entry
        repeat (520) @(posedge clk_sys);
        rd(REG_HITS, 32'h0, RESP_OKAY);
        wr(REG_IDX, 32'h0, RESP_OKAY);
        wr(REG_CMD, 32'(CMD_DELETE), RESP_SLVERR);
        rd(8'hfc, 32'h0, RESP_SLVERR);
        wr(REG_CTRL, 32'h2, RESP_OKAY);
        go(fr(5'd3, 8'h00, FC_OTHER, 16'h0600, s, UNI, 14'd1517), miss);
        go(fr(5'd9, 8'h00, FC_OTHER, 16'h8899, s, 48'h0180c2000002, 14'd64), ex(1, 0, 0, 0, 0, 0, 0, 0, 0, 0));
        drain();
        summarize();
    end
endmodule
